// ---- core/ltv_pkg.sv ----
/*
 package for the thermal, output-voltage and droop register pair.
 assumes a byte-wide register port from the serial front end in the same clock domain.
*/
package ltv_pkg;
    localparam logic [7:0] LTV_ADDR_THERM = 8'h06;
    localparam logic [7:0] LTV_ADDR_DROOP = 8'h07;
    // field positions, register 0x06
    localparam int LTV_BIT_TS_EN = 7;
    localparam int LTV_BIT_HOT = 6;
    localparam int LTV_BIT_WARN = 5;
    localparam int LTV_BIT_HDR = 4;
    localparam int LTV_POS_VOUT = 0;
    // field positions, register 0x07
    localparam int LTV_BIT_DM_EN = 7;
    localparam int LTV_POS_DROOP = 4;
    // reset values
    localparam logic LTV_RST_TS_EN = 1'b0;
    localparam logic LTV_RST_HOT = 1'b0;
    localparam logic [3:0] LTV_RST_VOUT = 4'h9;
    localparam logic LTV_RST_DM_EN = 1'b0;
    localparam logic [2:0] LTV_RST_DROOP = 3'h4;
    localparam logic LTV_RST_WARN = 1'b0;
    localparam logic LTV_RST_HDR = 1'b0;
    localparam logic [7:0] LTV_RST_RDATA = 8'h00;
    // droop limit in mV: base plus step per code
    localparam int LTV_DROOP_BASE_MV = 50;
    localparam int LTV_DROOP_STEP_MV = 25;
    // output voltage in mV: base plus step per code
    localparam int LTV_VOUT_BASE_MV = 3825;
    localparam int LTV_VOUT_STEP_MV = 125;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ltv_req_t;

    typedef struct packed {
        logic below_warn;
        logic below_hot;
        logic headroom_ok;
        logic strobe_active;
        logic rampdown;
    } ltv_sense_t;
endpackage

// ---- core/ltv_regs.sv ----
/*
 thermal / vout / droop control and status registers.
 assumes req comes from the serial slave on ref_clk, one-cycle rd/wr strobes;
 sense inputs come from analog comparators and are synchronised here.
 rdata is registered and holds until the next read;
 overtemp_shutdown follows the hot flag and drops only when software clears it.
*/
`timescale 1ns/1ns
// Behaviour
// [RULE1] temperature monitoring runs only when enabled
// [RULE2] hot flag sets below hot threshold
// [RULE3] hot flag cleared only by writing zero
// [RULE4] warning flag sets below warning threshold
// [RULE5] warning flag read-only, cleared after read
// [RULE6] headroom bit updated during strobe before rampdown
// [RULE7] vout field reads calibration result
// [RULE8] vout write sets target voltage code
// [RULE9] host writes vout after voltage mode enabled
// [RULE10] droop monitoring runs only when enabled
// [RULE11] three-bit code selects droop limit
// [RULE12] droop register layout and reset values
// [RULE13] hot flag forces shutdown and stays latched
// [RULE14] thermal register layout at 0x06
// [RULE15] read-only fields and bit 3 ignore writes
module ltv_regs
    import ltv_pkg::*;
#(
    parameter logic [2:0] REV_CODE = 3'h3 // arbitrary value
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire ltv_req_t req,
    output logic [7:0] rdata,
    // analog and calibration side
    input wire ltv_sense_t sense,
    input wire logic [3:0] selfcal_code,
    // controls to the power stage
    output logic temp_monitor_enable,
    output logic droop_monitor_enable,
    output logic [2:0] droop_threshold_select,
    output logic [3:0] vout_target_code,
    output logic overtemp_shutdown
);
    ltv_sense_t s1_r;
    ltv_sense_t s2_r;
    logic ts_en_r;
    logic hot_r;
    logic warn_r;
    logic hdr_r;
    logic [3:0] vout_r;
    logic dm_en_r;
    logic [2:0] droop_r;
    logic [7:0] rdata_r;
    logic shut_r;

    // decode, events and next values
    logic sel_th;
    logic sel_dr;
    logic wr_th;
    logic wr_dr;
    logic rd_th;
    logic rd_dr;
    logic rd_none;
    logic hot_clr;
    logic hot_evt;
    logic warn_evt;
    logic hdr_upd;
    logic ts_en_nxt;
    logic hot_nxt;
    logic warn_nxt;
    logic hdr_nxt;
    logic [3:0] vout_nxt;
    logic dm_en_nxt;
    logic [2:0] droop_nxt;
    logic [7:0] th_word;
    logic [7:0] dr_word;
    logic [7:0] rd_nxt;

    assign sel_th = (req.addr == LTV_ADDR_THERM); // [RULE14]
    assign sel_dr = (req.addr == LTV_ADDR_DROOP); // [RULE12]
    assign wr_th = req.wr && sel_th;
    assign wr_dr = req.wr && sel_dr;
    assign rd_th = req.rd && sel_th;
    assign rd_dr = req.rd && sel_dr;
    assign rd_none = req.rd && !sel_th && !sel_dr;
    assign hot_clr = wr_th && !req.wdata[LTV_BIT_HOT]; // [RULE3]
    // hot and warning comparators only count while monitoring is on
    assign hot_evt = ts_en_r && s2_r.below_hot; // [RULE1] [RULE2]
    assign warn_evt = ts_en_r && s2_r.below_warn; // [RULE1] [RULE4]
    assign hdr_upd = s2_r.strobe_active && !s2_r.rampdown; // [RULE6]
    assign ts_en_nxt = wr_th ? req.wdata[LTV_BIT_TS_EN] : ts_en_r; // [RULE1]
    // set wins over a same-cycle clear
    assign hot_nxt = hot_evt ? 1'b1 : (hot_clr ? 1'b0 : hot_r); // [RULE3] [RULE13]
    assign warn_nxt = warn_evt ? 1'b1 : (rd_th ? 1'b0 : warn_r); // [RULE5]
    assign hdr_nxt = hdr_upd ? s2_r.headroom_ok : hdr_r; // [RULE6]
    assign vout_nxt = wr_th ? req.wdata[LTV_POS_VOUT +: 4] : vout_r; // [RULE8]
    assign dm_en_nxt = wr_dr ? req.wdata[LTV_BIT_DM_EN] : dm_en_r; // [RULE10]
    assign droop_nxt = wr_dr ? req.wdata[LTV_POS_DROOP +: 3] : droop_r; // [RULE11] [RULE12]
    // vout nibble reads calibration, never the target
    assign th_word = {ts_en_r, hot_r, warn_r, hdr_r, selfcal_code}; // [RULE14] [RULE7]
    assign dr_word = {dm_en_r, droop_r, 1'b0, REV_CODE}; // [RULE12] [RULE15]
    assign rd_nxt = rd_th ? th_word :
        rd_dr ? dr_word :
        rd_none ? 8'h00 :
        rdata_r;

    // two-flop synchroniser for the comparator levels
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
        end else begin
            s1_r <= sense;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s2_r <= '0;
        end else begin
            s2_r <= s1_r;
        end
    end

    // one flop group per field
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ts_en_r <= LTV_RST_TS_EN;
        end else begin
            ts_en_r <= ts_en_nxt; // [RULE1]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hot_r <= LTV_RST_HOT;
        end else begin
            hot_r <= hot_nxt; // [RULE3]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            warn_r <= LTV_RST_WARN;
        end else begin
            warn_r <= warn_nxt; // [RULE5]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hdr_r <= LTV_RST_HDR;
        end else begin
            hdr_r <= hdr_nxt; // [RULE6]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shut_r <= LTV_RST_HOT;
        end else begin
            shut_r <= hot_nxt; // [RULE13]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= LTV_RST_RDATA;
        end else begin
            rdata_r <= rd_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vout_r <= LTV_RST_VOUT;
        end else begin
            vout_r <= vout_nxt; // [RULE8]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dm_en_r <= LTV_RST_DM_EN;
        end else begin
            dm_en_r <= dm_en_nxt; // [RULE10]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            droop_r <= LTV_RST_DROOP;
        end else begin
            droop_r <= droop_nxt; // [RULE11]
        end
    end

    assign rdata = rdata_r;
    assign temp_monitor_enable = ts_en_r;
    assign droop_monitor_enable = dm_en_r;
    assign droop_threshold_select = droop_r;
    assign vout_target_code = vout_r;
    assign overtemp_shutdown = shut_r;

    // hot flag and shutdown
    AST_HOT_SET: assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
        hot_evt |=> hot_r && overtemp_shutdown)
        else $error("hot flag not set");
    AST_HOT_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
        hot_r && !(wr_th && !req.wdata[LTV_BIT_HOT]) |=> hot_r)
        else $error("hot flag lost");
    AST_HOT_CLR: assert property (@(posedge ref_clk) disable iff (rst) // [RULE13]
        wr_th && !req.wdata[LTV_BIT_HOT] && !hot_evt |=> !hot_r)
        else $error("hot not cleared");
    AST_HOT_WINS: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
        hot_evt && hot_clr |=> hot_r)
        else $error("hot clear beat a new event");
    AST_HOT_NOWR: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
        !hot_r && !hot_evt |=> !hot_r)
        else $error("hot set without event");
    AST_TS_OFF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
        !ts_en_r && !hot_r |=> !hot_r)
        else $error("hot set while monitor off");
    AST_SHUT_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE13]
        overtemp_shutdown && !hot_clr |=> overtemp_shutdown)
        else $error("shutdown released without clear");
    AST_SHUT_OFF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE13]
        !overtemp_shutdown && !hot_evt |=> !overtemp_shutdown)
        else $error("shutdown without hot event");

    // warning flag
    AST_WARN_SET: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
        warn_evt |=> warn_r)
        else $error("warning not set");
    AST_WARN_RD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
        rd_th && !warn_evt |=> !warn_r)
        else $error("warning not cleared by read");
    AST_WARN_WINS: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
        rd_th && warn_evt |=> warn_r)
        else $error("read clear beat a new warning");
    AST_WARN_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
        warn_r && !rd_th |=> warn_r)
        else $error("warning lost without read");
    AST_WARN_OFF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
        !ts_en_r && !warn_r |=> !warn_r)
        else $error("warning set while monitor off");
    AST_WARN_NOWR: assert property (@(posedge ref_clk) disable iff (rst) // [RULE15]
        !warn_r && !warn_evt |=> !warn_r)
        else $error("warning set without event");
    AST_WARN_RD_DR: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
        rd_dr && warn_r |=> warn_r)
        else $error("droop read cleared warning");

    // monitor enable and headroom
    AST_TS_EN_WR: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
        wr_th |=> temp_monitor_enable == $past(req.wdata[7]))
        else $error("monitor enable not written");
    AST_TS_EN_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
        !wr_th |=> $stable(temp_monitor_enable))
        else $error("monitor enable changed");
    AST_HDR: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
        !hdr_upd |=> $stable(hdr_r))
        else $error("headroom changed outside strobe");
    AST_HDR_UPD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
        hdr_upd |=> hdr_r == $past(s2_r.headroom_ok))
        else $error("headroom not sampled");

    // output voltage target
    AST_VOUT_WR: assert property (@(posedge ref_clk) disable iff (rst) // [RULE8]
        wr_th |=> vout_target_code == $past(req.wdata[3:0]))
        else $error("vout target wrong");
    AST_VOUT_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE8]
        !wr_th |=> $stable(vout_target_code))
        else $error("vout target changed");

    // droop monitor
    AST_DROOP_WR: assert property (@(posedge ref_clk) disable iff (rst) // [RULE11]
        wr_dr |=> droop_threshold_select == $past(req.wdata[6:4]))
        else $error("droop code");
    AST_DM_EN: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
        wr_dr |=> droop_monitor_enable == $past(req.wdata[7]))
        else $error("droop enable");
    AST_DR_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
        !wr_dr |=> $stable(droop_threshold_select) && $stable(droop_monitor_enable))
        else $error("droop fields changed");

    // read data
    AST_RD_TH: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
        rd_th |=> rdata[3:0] == $past(selfcal_code))
        else $error("vout read not calibration");
    AST_RD_TOP: assert property (@(posedge ref_clk) disable iff (rst) // [RULE14]
        rd_th |=> rdata[7:4] == $past({temp_monitor_enable, hot_r, warn_r, hdr_r}))
        else $error("thermal read fields wrong");
    AST_RD_DR: assert property (@(posedge ref_clk) disable iff (rst) // [RULE15]
        req.rd && sel_dr |=> rdata[3] == 1'b0 && rdata[2:0] == REV_CODE)
        else $error("rev read");
    AST_RD_DR_TOP: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
        rd_dr |=> rdata[7:4] == $past({droop_monitor_enable, droop_threshold_select}))
        else $error("droop read fields wrong");
    AST_RD_NONE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE15]
        rd_none |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE14]
        !req.rd |=> $stable(rdata))
        else $error("read data changed without read");
endmodule

// ---- verif/ltv_host.sv ----
/*
 host model: issues single-byte register reads and writes.
 assumes ltv_pkg and a free-running ref_clk.
*/
`timescale 1ns/1ns
module ltv_host
    import ltv_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register port
    output ltv_req_t req
);
    initial req = '0;
    // one-cycle strobe, then an idle edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        req <= {!w, w, a, d};
        @(posedge ref_clk);
        req <= '0;
        @(posedge ref_clk);
    endtask
endmodule

// ---- verif/ltv_regs_tb.sv ----
/*
 bench for the thermal, vout and droop registers.
 assumes ltv_pkg, ltv_regs and the host model ltv_host.
*/
`timescale 1ns/1ns
module ltv_regs_tb import ltv_pkg::*;;
    localparam logic [2:0] REV = 3'h5;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    ltv_req_t req;
    logic [7:0] rdata;
    ltv_sense_t sense = '0;
    logic [3:0] sc = '0;
    logic ten, den, shut;
    logic [2:0] thr;
    logic [3:0] vt, v;
    logic vmode_on = 1'b0;
    logic [16:0] seed = 17'd72977;
    int miscompares = 0;
    int checks_done = 0;
    ltv_host host (.ref_clk(ref_clk), .req(req));
    ltv_regs #(.REV_CODE(REV)) dut (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
        .sense(sense), .selfcal_code(sc), .temp_monitor_enable(ten),
        .droop_monitor_enable(den), .droop_threshold_select(thr),
        .vout_target_code(vt), .overtemp_shutdown(shut));
    initial forever #5 ref_clk = ~ref_clk;
    function automatic logic [16:0] lfsr(input logic [16:0] x);
        return {x[15:0], x[16] ^ x[13]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // read 0x06 with a fresh calibration code on the input
    task automatic rd06(input logic [3:0] top);
        seed = lfsr(seed);
        sc <= seed[3:0];
        host.xfer(1'b0, LTV_ADDR_THERM, 8'h00);
        check(rdata, {top, sc});
    endtask
    // comparator levels, then let the synchroniser settle
    task automatic sn(input ltv_sense_t s);
        sense <= s;
        repeat (4) @(posedge ref_clk);
    endtask
    // vout targets go out only once voltage mode is up
    task automatic wr_vout(input logic [7:0] d);
        if (!vmode_on) begin
            vmode_on = 1'b1;
            @(posedge ref_clk);
        end
        host.xfer(1'b1, LTV_ADDR_THERM, d);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check({den, thr, vt}, {1'b0, 3'h4, 4'h9});
        rd06(4'h0);
        host.xfer(1'b0, LTV_ADDR_DROOP, 8'h00);
        check(rdata, {1'b0, 3'h4, 1'b0, REV});
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            host.xfer(1'b1, LTV_ADDR_DROOP, {seed[7], i[2:0], 4'hf});
            host.xfer(1'b0, LTV_ADDR_DROOP, 8'h00);
            check(rdata, {seed[7], i[2:0], 1'b0, REV});
            check({4'h0, den, thr}, {4'h0, seed[7], i[2:0]});
        end
        sn(5'b11000);
        rd06(4'h0);
        v = seed[3:0];
        wr_vout({4'hb, v});
        check({ten, vt, 3'h0}, {1'b1, v, 3'h0});
        sn(5'b11000);
        check({7'h0, shut}, 8'h01);
        rd06(4'he);
        wr_vout({4'h8, ~v});
        rd06(4'he);
        check({4'h0, vt}, {4'h0, ~v});
        check({7'h0, shut}, 8'h01);
        sn(5'b00000);
        rd06(4'he);
        rd06(4'hc);
        wr_vout(8'hf0);
        rd06(4'hc);
        wr_vout(8'h80);
        rd06(4'h8);
        check({7'h0, shut}, 8'h00);
        sn(5'b00110);
        rd06(4'h9);
        sn(5'b00011);
        rd06(4'h9);
        sn(5'b00010);
        rd06(4'h8);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check({shut, ten, den, thr, 2'h0}, {1'b0, 1'b0, 1'b0, 3'h4, 2'h0});
        check({vt, 4'h0}, {4'h9, 4'h0});
        check(rdata, 8'h00);
        rd06(4'h0);
        host.xfer(1'b0, 8'h10, 8'h00);
        check(rdata, 8'h00);
        summarize();
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        miscompares++;
        summarize();
    end
endmodule
